/* core/osd_adc_dev.sv */
// converter end: conversion sequencing, lowpass filter and down-sampler
`timescale 1ns/1ps
module osd_adc_dev #(
    parameter int REINIT_CYCLES = osd_pkg::OSD_REINIT_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // link to host
    osd_link_if.dev link,
    // analog core side
    input wire logic [osd_pkg::OSD_WORD_W-1:0] core_result,
    output logic core_power,
    output logic acquiring,
    // straps and status
    input wire logic ratio_strap_high,
    input wire logic ratio_strap_low,
    output logic init_done
);
    import osd_pkg::*;

    typedef enum logic [1:0] {ST_INIT, ST_ACQ, ST_CONV} osd_dev_state_e;

    osd_dev_state_e state_q;
    logic [13:0] init_cnt_q;
    logic [5:0] conv_cnt_q;
    logic smp_s1_q, smp_s2_q, smp_s3_q;
    logic aln_s1_q, aln_s2_q, aln_s3_q;
    logic [1:0] strap_s1_q, strap_s2_q;
    logic [1:0] sel_q;
    logic [OSD_CNT_W-1:0] phase_q;
    logic [OSD_CNT_W-1:0] df_last;
    logic signed [OSD_WORD_W-1:0] filt_q;
    logic signed [OSD_WORD_W-1:0] filt_d;
    logic signed [OSD_WORD_W:0] diff;
    logic [OSD_WORD_W-1:0] out_q;
    logic ready_q;
    logic smp_rise, aln_rise, conv_done, phase_move, last_of_ratio;

    // pin synchronisers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            smp_s1_q <= 1'b0;
            smp_s2_q <= 1'b0;
            smp_s3_q <= 1'b0;
            aln_s1_q <= 1'b0;
            aln_s2_q <= 1'b0;
            aln_s3_q <= 1'b0;
            strap_s1_q <= OSD_SEL_RST;
            strap_s2_q <= OSD_SEL_RST;
        end else begin
            smp_s1_q <= link.sample_clk;
            smp_s2_q <= smp_s1_q;
            smp_s3_q <= smp_s2_q;
            aln_s1_q <= link.align_pulse;
            aln_s2_q <= aln_s1_q;
            aln_s3_q <= aln_s2_q;
            strap_s1_q <= {ratio_strap_high, ratio_strap_low};
            strap_s2_q <= strap_s1_q;
        end
    end

    assign smp_rise = smp_s2_q & ~smp_s3_q;
    assign aln_rise = aln_s2_q & ~aln_s3_q;
    assign conv_done = (state_q == ST_CONV) && (conv_cnt_q == 6'(OSD_CONV_CYCLES - 1));

    // reinitialisation after power-on reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            init_cnt_q <= 14'h0000;
        end else if (state_q == ST_INIT) begin
            init_cnt_q <= init_cnt_q + 14'h0001;
        end
    end

    // strap code latched as reinitialisation ends
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sel_q <= OSD_SEL_RST;
        end else if (state_q == ST_INIT) begin
            sel_q <= strap_s2_q;
        end
    end

    // conversion sequencing
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= ST_INIT;
        end else begin
            case (state_q)
                ST_INIT: begin
                    if (init_cnt_q == 14'(REINIT_CYCLES - 1)) begin
                        state_q <= ST_ACQ;
                    end
                end
                ST_ACQ: begin
                    if (smp_rise) begin
                        state_q <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (conv_done) begin
                        state_q <= ST_ACQ;
                    end
                end
                default: begin
                    state_q <= ST_INIT;
                end
            endcase
        end
    end

    // self-timed conversion length, rate independent
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            conv_cnt_q <= 6'h00;
        end else if (state_q != ST_CONV) begin
            conv_cnt_q <= 6'h00;
        end else if (!conv_done) begin
            conv_cnt_q <= conv_cnt_q + 6'h01;
        end
    end

    assign link.busy = (state_q == ST_CONV);
    assign core_power = (state_q == ST_CONV);
    assign acquiring = (state_q == ST_ACQ);
    assign init_done = (state_q != ST_INIT);

    // down-sampler phase
    assign df_last = osd_df_of(sel_q) - 15'h0001;
    assign last_of_ratio = (phase_q == df_last);
    assign phase_move = aln_rise && (phase_q != 15'h0000);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            phase_q <= 15'h0000;
        end else if (aln_rise) begin
            phase_q <= 15'h0000;
        end else if (conv_done) begin
            phase_q <= last_of_ratio ? 15'h0000 : phase_q + 15'h0001;
        end
    end

    // lowpass filter, one word per conversion
    always_comb begin
        diff = {core_result[OSD_WORD_W-1], core_result} - {filt_q[OSD_WORD_W-1], filt_q};
        filt_d = filt_q + OSD_WORD_W'(diff >>> osd_shift_of(sel_q));
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            filt_q <= OSD_WORD_RST;
        end else if (phase_move) begin
            filt_q <= OSD_WORD_RST;
        end else if (conv_done) begin
            filt_q <= filt_d;
        end
    end

    // decimated output word
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            out_q <= OSD_WORD_RST;
        end else if (conv_done && last_of_ratio && !aln_rise) begin
            out_q <= filt_d;
        end
    end

    assign link.out_word = out_q;

    // ready flag over every ratio-th conversion
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ready_q <= 1'b0;
        end else if (state_q == ST_ACQ && smp_rise && last_of_ratio) begin
            ready_q <= 1'b1;
        end else if (conv_done || aln_rise) begin
            ready_q <= 1'b0;
        end
    end

    assign link.filtered_ready_flag = ready_q;
endmodule : osd_adc_dev

/* shared/osd_pkg.sv */
// shared constants and helpers for the oversampling converter ends
package osd_pkg;
    localparam int OSD_WORD_W = 32;
    localparam int OSD_CNT_W = 15;
    localparam int OSD_CLK_PERIOD_NS = 25;
    // conversion timing
    localparam int OSD_CONV_TIME_NS = 652;
    localparam int OSD_CONV_CYCLES = OSD_CONV_TIME_NS / OSD_CLK_PERIOD_NS;
    localparam int OSD_ACQ_TIME_NS = 335;
    localparam int OSD_ACQ_CYCLES = (OSD_ACQ_TIME_NS + OSD_CLK_PERIOD_NS - 1) / OSD_CLK_PERIOD_NS;
    localparam int OSD_SMPL_PERIOD_NS = 1000;
    localparam int OSD_SMPL_CYCLES = (OSD_SMPL_PERIOD_NS + OSD_CLK_PERIOD_NS - 1) / OSD_CLK_PERIOD_NS;
    localparam int OSD_FALL_WINDOW_NS = 40;
    localparam int OSD_HIGH_CYCLES = OSD_FALL_WINDOW_NS / OSD_CLK_PERIOD_NS;
    localparam int OSD_REINIT_TIME_US = 200;
    localparam int OSD_REINIT_CYCLES = OSD_REINIT_TIME_US * 1000 / OSD_CLK_PERIOD_NS;
    // reset values
    localparam logic [OSD_WORD_W-1:0] OSD_WORD_RST = 32'h0000_0000;
    localparam logic [1:0] OSD_SEL_RST = 2'h0;
    // decimation ratios by strap code
    localparam logic [OSD_CNT_W-1:0] OSD_DF_256 = 15'h0100;
    localparam logic [OSD_CNT_W-1:0] OSD_DF_1024 = 15'h0400;
    localparam logic [OSD_CNT_W-1:0] OSD_DF_4096 = 15'h1000;
    localparam logic [OSD_CNT_W-1:0] OSD_DF_16384 = 15'h4000;

    function automatic logic [OSD_CNT_W-1:0] osd_df_of(input logic [1:0] sel);
        case (sel)
            2'h0: osd_df_of = OSD_DF_256;
            2'h1: osd_df_of = OSD_DF_1024;
            2'h2: osd_df_of = OSD_DF_4096;
            default: osd_df_of = OSD_DF_16384;
        endcase
    endfunction : osd_df_of

    // lowpass weight shift per strap code
    function automatic logic [4:0] osd_shift_of(input logic [1:0] sel);
        osd_shift_of = 5'h04 + {3'h0, sel};
    endfunction : osd_shift_of
endpackage : osd_pkg

/* shared/osd_link_if.sv */
// link between the converter and its host controller
`timescale 1ns/1ps
interface osd_link_if;
    logic sample_clk;
    logic align_pulse;
    logic busy;
    logic filtered_ready_flag;
    logic [31:0] out_word;

    modport dev (
        input sample_clk,
        input align_pulse,
        output busy,
        output filtered_ready_flag,
        output out_word
    );
    modport host (
        output sample_clk,
        output align_pulse,
        input busy,
        input filtered_ready_flag,
        input out_word
    );
endinterface : osd_link_if

/* core/osd_adc_host.sv */
// host end: sample clock pacing, alignment and output word capture
`timescale 1ns/1ps
module osd_adc_host #(
    parameter int REINIT_CYCLES = osd_pkg::OSD_REINIT_CYCLES,
    parameter int SMPL_CYCLES = osd_pkg::OSD_SMPL_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // link to converter
    osd_link_if.host link,
    // user control
    input wire logic run,
    input wire logic align_req,
    // decimated words out
    output logic [osd_pkg::OSD_WORD_W-1:0] word_data,
    output logic word_valid,
    input wire logic word_ready
);
    import osd_pkg::*;

    typedef enum logic [2:0] {H_INIT, H_IDLE, H_HIGH, H_WAITB, H_CONV} osd_host_state_e;

    osd_host_state_e state_q;
    logic [13:0] init_cnt_q;
    logic [7:0] per_cnt_q;
    logic [7:0] acq_cnt_q;
    logic bsy_s1_q, bsy_s2_q;
    logic rdy_s1_q, rdy_s2_q, rdy_s3_q;
    logic [OSD_WORD_W-1:0] dat_s1_q, dat_s2_q;
    logic align_q;
    logic [OSD_WORD_W-1:0] mem_q [2];
    logic wr_q, rd_q;
    logic [1:0] count_q;
    logic start, push, pop;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bsy_s1_q <= 1'b0;
            bsy_s2_q <= 1'b0;
            rdy_s1_q <= 1'b0;
            rdy_s2_q <= 1'b0;
            rdy_s3_q <= 1'b0;
            dat_s1_q <= OSD_WORD_RST;
            dat_s2_q <= OSD_WORD_RST;
        end else begin
            bsy_s1_q <= link.busy;
            bsy_s2_q <= bsy_s1_q;
            rdy_s1_q <= link.filtered_ready_flag;
            rdy_s2_q <= rdy_s1_q;
            rdy_s3_q <= rdy_s2_q;
            dat_s1_q <= link.out_word;
            dat_s2_q <= dat_s1_q;
        end
    end

    // stalled by a full buffer
    assign start = (state_q == H_IDLE) && run && (count_q != 2'h2)
        && (per_cnt_q >= 8'(SMPL_CYCLES - 1)) && (acq_cnt_q >= 8'(OSD_ACQ_CYCLES));

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            init_cnt_q <= 14'h0000;
        end else if (state_q == H_INIT) begin
            init_cnt_q <= init_cnt_q + 14'h0001;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= H_INIT;
        end else begin
            case (state_q)
                H_INIT: begin
                    if (init_cnt_q == 14'(REINIT_CYCLES - 1)) begin
                        state_q <= H_IDLE;
                    end
                end
                H_IDLE: begin
                    if (start) begin
                        state_q <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    state_q <= H_WAITB;
                end
                H_WAITB: begin
                    if (bsy_s2_q) begin
                        state_q <= H_CONV;
                    end
                end
                H_CONV: begin
                    if (!bsy_s2_q) begin
                        state_q <= H_IDLE;
                    end
                end
                default: begin
                    state_q <= H_INIT;
                end
            endcase
        end
    end

    // start spacing and acquisition time
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            per_cnt_q <= 8'h00;
            acq_cnt_q <= 8'h00;
        end else begin
            per_cnt_q <= start ? 8'h00 : (per_cnt_q == 8'hff ? per_cnt_q : per_cnt_q + 8'h01);
            if (state_q != H_IDLE) begin
                acq_cnt_q <= 8'h00;
            end else if (acq_cnt_q != 8'hff) begin
                acq_cnt_q <= acq_cnt_q + 8'h01;
            end
        end
    end

    assign link.sample_clk = (state_q == H_HIGH);

    // alignment pulse held until the next start
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            align_q <= 1'b0;
        end else if (align_req) begin
            align_q <= 1'b1;
        end else if (start) begin
            align_q <= 1'b0;
        end
    end

    assign link.align_pulse = align_q;

    // two-entry buffer filled when the ready flag falls
    assign push = ~rdy_s2_q & rdy_s3_q & (count_q != 2'h2);
    assign pop = word_valid & word_ready;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mem_q[0] <= OSD_WORD_RST;
            mem_q[1] <= OSD_WORD_RST;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            if (push) begin
                mem_q[wr_q] <= dat_s2_q;
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end

    assign word_valid = (count_q != 2'h0);
    assign word_data = mem_q[rd_q];
endmodule : osd_adc_host

/* testbench/osd_link_sva.sv */
// timing checks on the converter link
`timescale 1ns/1ps
module osd_link_sva
    import osd_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // link signals
    input wire logic sample_clk,
    input wire logic align_pulse,
    input wire logic busy,
    input wire logic filtered_ready_flag,
    input wire logic [31:0] out_word
);
    logic [7:0] busy_cnt_q;
    logic [7:0] gap_q;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // cycles busy has been high
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy_cnt_q <= 8'h00;
        end else begin
            busy_cnt_q <= busy ? busy_cnt_q + 8'h01 : 8'h00;
        end
    end

    // cycles since sample clock was last high
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gap_q <= 8'hff;
        end else begin
            gap_q <= sample_clk ? 8'h00 : (gap_q == 8'hff ? 8'hff : gap_q + 8'h01);
        end
    end

    property p_start;
        $rose(sample_clk) && !busy |-> ##[2:4] $rose(busy);
    endproperty
    a_start: assert property (p_start) else $error("busy did not follow start");
    property p_busy_len;
        $fell(busy) |-> busy_cnt_q == 8'(OSD_CONV_CYCLES);
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    property p_conv_bound;
        busy |-> busy_cnt_q < 8'(OSD_CONV_CYCLES);
    endproperty
    a_conv_bound: assert property (p_conv_bound) else $error("conversion too long");
    property p_idle;
        $fell(busy) |-> !busy [*8];
    endproperty
    a_idle: assert property (p_idle) else $error("no acquisition gap");
    property p_flag_in;
        filtered_ready_flag |-> busy;
    endproperty
    a_flag_in: assert property (p_flag_in) else $error("flag outside conversion");
    property p_flag_rise;
        $rose(filtered_ready_flag) |-> $rose(busy);
    endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("flag rose late");
    property p_flag_fall;
        $fell(busy) |-> !filtered_ready_flag;
    endproperty
    a_flag_fall: assert property (p_flag_fall) else $error("flag not cleared at end");
    property p_word_hold;
        !$stable(out_word) |-> $fell(filtered_ready_flag);
    endproperty
    a_word_hold: assert property (p_word_hold) else $error("word changed off update");
    property p_clk_fall;
        $rose(sample_clk) |=> !sample_clk;
    endproperty
    a_clk_fall: assert property (p_clk_fall) else $error("sample clock held high");
    property p_spacing;
        $rose(sample_clk) |-> gap_q >= 8'h27;
    endproperty
    a_spacing: assert property (p_spacing) else $error("starts too close");
    c_align: cover property ($rose(align_pulse));
endmodule : osd_link_sva

/* testbench/oversampling_adc_conversion_decimation_bench.sv */
// self-checking bench for both converter ends
`timescale 1ns/1ps
module oversampling_adc_conversion_decimation_bench;
    import osd_pkg::*;
    localparam int REINIT = 20;
    logic clock;
    logic rst;
    logic run;
    logic align_req;
    logic word_ready;
    logic word_valid;
    logic [31:0] word_data;
    logic strap_hi;
    logic strap_lo;
    logic core_power;
    logic acquiring;
    logic init_done;
    logic signed [31:0] core_x;
    logic signed [31:0] y;
    logic busy_prev;
    logic [31:0] exp_q[$];
    int df;
    int sh;
    int phase;
    int nconv;
    int fail_count;
    int samples_checked;

    osd_link_if link ();
    osd_adc_dev #(.REINIT_CYCLES(REINIT)) i_osd_adc_dev (.clock(clock), .rst(rst), .link(link),
        .core_result(core_x), .core_power(core_power), .acquiring(acquiring), .ratio_strap_high(strap_hi),
        .ratio_strap_low(strap_lo), .init_done(init_done));
    osd_adc_host #(.REINIT_CYCLES(REINIT)) i_osd_adc_host (.clock(clock), .rst(rst), .link(link),
        .run(run), .align_req(align_req), .word_data(word_data), .word_valid(word_valid),
        .word_ready(word_ready));
    osd_link_sva i_osd_link_sva (.clock(clock), .rst(rst), .sample_clk(link.sample_clk),
        .align_pulse(link.align_pulse), .busy(link.busy), .filtered_ready_flag(link.filtered_ready_flag),
        .out_word(link.out_word));

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic final_report();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    task automatic bail(input logic ok);
        if (!ok) begin
            fail_count++;
            final_report();
        end
    endtask : bail

    task automatic restart(input int code);
        rst = 1'b1;
        run = 1'b0;
        {strap_hi, strap_lo} = code[1:0];
        df = 256 << (2 * code);
        sh = 4 + code;
        y = 32'sh0;
        phase = 0;
        nconv = 0;
        exp_q.delete();
        repeat (10) @(negedge clock);
        rst = 1'b0;
        run = 1'b1;
        check({31'h0, init_done}, 32'h0);
    endtask : restart

    task automatic wait_conv(input int n);
        int i;
        for (i = 0; i < n * 60 + 500 && (nconv < n || link.busy); i++) @(negedge clock);
        // let the reference model take the last conversion first
        @(negedge clock);
        bail(nconv >= n && !link.busy);
    endtask : wait_conv

    task automatic pop();
        int i;
        for (i = 0; i < 100 && word_valid !== 1'b1; i++) @(negedge clock);
        bail(word_valid === 1'b1);
        check(word_data, exp_q.size() > 0 ? exp_q.pop_front() : 32'hx);
        word_ready = 1'b1;
        @(negedge clock);
        word_ready = 1'b0;
        @(negedge clock);
    endtask : pop

    // reference model of the conversion stream
    always @(negedge clock) begin
        if (!rst && link.busy && !busy_prev) begin
            nconv++;
            check({31'h0, link.filtered_ready_flag}, {31'h0, phase == df - 1});
            check({31'h0, core_power}, 32'h1);
            check({30'h0, acquiring, init_done}, 32'h1);
        end
        if (!rst && !link.busy && busy_prev) begin
            check({31'h0, core_power}, 32'h0);
            check({31'h0, acquiring}, 32'h1);
            y = y + ((core_x - y) >>> sh);
            phase = (phase + 1) % df;
            if (phase == 0) begin
                exp_q.push_back(y);
            end
        end
        busy_prev = link.busy;
    end

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial begin
        rst = 1'b1;
        run = 1'b0;
        align_req = 1'b0;
        word_ready = 1'b0;
        strap_hi = 1'b0;
        strap_lo = 1'b0;
        core_x = 32'sh0040_0000;
        busy_prev = 1'b0;
        fail_count = 0;
        samples_checked = 0;
        restart(0);
        wait_conv(10);
        align_req = 1'b1;
        @(negedge clock);
        align_req = 1'b0;
        if (phase != 0) begin
            y = 32'sh0;
        end
        phase = 0;
        wait_conv(266);
        core_x = 32'sh0001_0000;
        wait_conv(522);
        repeat (200) @(negedge clock);
        check(nconv, 32'd522);
        pop();
        pop();
        restart(1);
        wait_conv(1024);
        pop();
        restart(2);
        wait_conv(270);
        check({31'h0, word_valid}, 32'h0);
        restart(3);
        wait_conv(270);
        check({31'h0, word_valid}, 32'h0);
        final_report();
    end
endmodule : oversampling_adc_conversion_decimation_bench
